// file: rtl/sre_core.sv
// sre_core: executes negate, nop, pop, push, relative call, soft reset and returns
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module sre_core
    import sre_pkg::*;
(
    input wire logic clk_i, // 100 MHz core clock
    input wire logic rst_i, // synchronous reset, active high
    input wire logic cyc_i, // wishbone cycle
    input wire logic stb_i, // wishbone strobe
    input wire logic we_i, // wishbone write enable
    input wire logic [7:0] adr_i, // wishbone byte address
    input wire logic [3:0] sel_i, // wishbone byte lanes
    input wire logic [31:0] dat_i, // wishbone write data
    output logic [31:0] dat_o, // wishbone read data
    output logic ack_o // wishbone acknowledge
);

    // ==================================================================
    // state
    sre_state_t state;
    logic [1:0] phase;
    logic cycle_idx;
    logic [15:0] instr;
    sre_op_t op;
    logic unsup;
    logic [20:0] pc;
    logic [7:0] wreg;
    sre_flags_t flags;
    logic [3:0] bank_selector;
    logic high_priority_global_enable;
    logic low_priority_global_enable;
    logic prio_mode;
    logic [7:0] working_shadow;
    sre_flags_t flags_shadow;
    logic [3:0] bank_selector_shadow;
    logic [7:0] pc_high_latch;
    logic [4:0] pc_upper_latch;
    logic [4:0] sp;
    logic [20:0] stack_mem [1:STACK_DEPTH];
    logic [20:0] stack_top;
    logic [7:0] operand;
    logic [11:0] mem_addr;
    logic [7:0] data_mem [0:MEM_WORDS-1];

    // ==================================================================
    // bus strobes and execution phase strobes
    logic req;
    logic sw_wr;
    logic idle_wr;
    logic q2;
    logic q3;
    logic q4;
    logic last_phase;
    logic soft_reset;
    logic [11:0] file_addr;
    logic [7:0] neg_res;
    logic [20:0] ret_addr;
    logic [20:0] call_target;
    logic [31:0] pc_wr, wreg_wr, flags_wr, bank_wr, maddr_wr;

    assign req = cyc_i && stb_i && !ack_o;
    assign sw_wr = req && we_i;
    // architectural state is only writable between instructions
    assign idle_wr = sw_wr && (state == ST_IDLE);
    assign q2 = (state == ST_RUN) && (phase == 2'h1) && !cycle_idx;
    assign q3 = (state == ST_RUN) && (phase == 2'h2) && !cycle_idx;
    assign q4 = (state == ST_RUN) && (phase == PHASE_LAST) && !cycle_idx;
    assign last_phase = (state == ST_RUN) && (phase == PHASE_LAST)
                        && (cycle_idx || !sre_two_cycle(op));
    assign soft_reset = q4 && (op == OP_SWRESET);
    assign stack_top = (sp == PTR_RST) ? PC_RST : stack_mem[sp];
    assign ret_addr = pc + PC_STEP;
    // 11-bit signed word offset, doubled into a byte offset
    assign call_target = ret_addr + {{9{instr[10]}}, instr[10:0], 1'b0};
    // access bank maps 00-7f to bank 0 and 80-ff to the top bank
    assign file_addr = instr[8] ? {bank_selector, instr[7:0]}
                                : {{4{instr[7]}}, instr[7:0]};
    assign neg_res = 8'h00 - operand;
    // lane merge kept apart: a part-select of a call result is not legal
    assign pc_wr = sre_merge({11'h0, pc}, dat_i, sel_i);
    assign wreg_wr = sre_merge({24'h0, wreg}, dat_i, sel_i);
    assign flags_wr = sre_merge({27'h0, flags}, dat_i, sel_i);
    assign bank_wr = sre_merge({28'h0, bank_selector}, dat_i, sel_i);
    assign maddr_wr = sre_merge({20'h0, mem_addr}, dat_i, sel_i);

    // ==================================================================
    // bus answer: one wait state, data registered with the ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end
        else
        begin
            ack_o <= req;
            dat_o <= 32'h0;
            if (req && !we_i)
            begin
                case (adr_i)
                    OFS_INSTR: dat_o <= {16'h0, instr};
                    OFS_STAT: dat_o <= {22'h0, unsup, sp, cycle_idx, phase, state == ST_RUN};
                    OFS_PC: dat_o <= {11'h0, pc};
                    OFS_WREG: dat_o <= {24'h0, wreg};
                    OFS_FLAGS: dat_o <= {27'h0, flags};
                    OFS_BANK: dat_o <= {28'h0, bank_selector};
                    OFS_INTCTL: dat_o <= {24'h0, high_priority_global_enable,
                                          low_priority_global_enable, 5'h0, prio_mode};
                    OFS_SHADOW: dat_o <= {12'h0, bank_selector_shadow, 3'h0, flags_shadow,
                                          working_shadow};
                    OFS_LATCH: dat_o <= {19'h0, pc_upper_latch, pc_high_latch};
                    OFS_STKTOP: dat_o <= {11'h0, stack_top};
                    OFS_MADDR: dat_o <= {20'h0, mem_addr};
                    OFS_MDATA: dat_o <= {24'h0, data_mem[mem_addr]};
                    default: dat_o <= 32'h0; // unmapped reads as zero
                endcase
            end
        end
    end

    // ==================================================================
    // sequencer: four phases per instruction cycle, one or two cycles
    always_ff @(posedge clk_i)
    begin
        if (rst_i || soft_reset)
        begin
            state <= ST_IDLE;
            phase <= 2'h0;
            cycle_idx <= 1'b0;
            instr <= 16'h0000;
            op <= OP_NOP;
            unsup <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    // an issue while busy is dropped; the bus still acks it
                    if (idle_wr && adr_i == OFS_INSTR)
                    begin
                        instr <= dat_i[15:0];
                        op <= sre_decode(dat_i[15:0]);
                        unsup <= (sre_decode(dat_i[15:0]) == OP_UNSUP);
                        phase <= 2'h0;
                        cycle_idx <= 1'b0;
                        state <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    phase <= phase + 2'h1;
                    if (phase == PHASE_LAST)
                        cycle_idx <= 1'b1; // second cycle does nothing
                    if (last_phase)
                    begin
                        cycle_idx <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==================================================================
    // program counter, written in the fourth phase of the first cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i || soft_reset)
            pc <= PC_RST;
        else if (q4)
        begin
            case (op)
                OP_RELATIVE_SUBROUTINE_CALL: pc <= call_target;
                OP_IRET, OP_LRET: pc <= stack_top;
                default: pc <= ret_addr;
            endcase
        end
        else if (idle_wr && adr_i == OFS_PC)
            pc <= pc_wr[20:0];
    end

    // ==================================================================
    // working register
    always_ff @(posedge clk_i)
    begin
        if (rst_i || soft_reset)
            wreg <= BYTE_RST;
        else if (q4 && op == OP_LRET)
            wreg <= instr[7:0];
        else if (q4 && op == OP_IRET && instr[0])
            wreg <= working_shadow;
        else if (idle_wr && adr_i == OFS_WREG)
            wreg <= wreg_wr[7:0];
    end

    // ==================================================================
    // arithmetic flags; negate is a subtract from zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i || soft_reset)
            flags <= FLAGS_RST;
        else if (q4 && op == OP_NEGATE)
        begin
            flags.neg <= neg_res[7];
            flags.overflow_flag <= (operand == 8'h80);
            flags.zero <= (neg_res == 8'h00);
            flags.digit_carry_flag <= (operand[3:0] == 4'h0);
            flags.carry <= (operand == 8'h00); // no borrow only for zero
        end
        else if (q4 && op == OP_IRET && instr[0])
            flags <= flags_shadow;
        else if (idle_wr && adr_i == OFS_FLAGS)
            flags <= flags_wr[4:0];
    end

    // ==================================================================
    // bank selector
    always_ff @(posedge clk_i)
    begin
        if (rst_i || soft_reset)
            bank_selector <= BANK_RST;
        else if (q4 && op == OP_IRET && instr[0])
            bank_selector <= bank_selector_shadow;
        else if (idle_wr && adr_i == OFS_BANK)
            bank_selector <= bank_wr[3:0];
    end

    // ==================================================================
    // interrupt enables; without priorities the high bit is the global enable
    always_ff @(posedge clk_i)
    begin
        if (rst_i || soft_reset)
        begin
            high_priority_global_enable <= 1'b0;
            low_priority_global_enable <= 1'b0;
            prio_mode <= 1'b0;
        end
        else if (q4 && op == OP_IRET)
        begin
            // the high level returns first, so re-arm it before the low one
            if (!prio_mode || !high_priority_global_enable)
                high_priority_global_enable <= 1'b1;
            else
                low_priority_global_enable <= 1'b1;
        end
        else if (idle_wr && adr_i == OFS_INTCTL && sel_i[0])
        begin
            high_priority_global_enable <= dat_i[INTCTL_HIGH_BIT];
            low_priority_global_enable <= dat_i[INTCTL_LOW_BIT];
            prio_mode <= dat_i[INTCTL_PRIO_BIT];
        end
    end

    // ==================================================================
    // shadow registers, loaded only by software in this slice
    always_ff @(posedge clk_i)
    begin
        if (rst_i || soft_reset)
        begin
            working_shadow <= BYTE_RST;
            flags_shadow <= FLAGS_RST;
            bank_selector_shadow <= BANK_RST;
        end
        else if (idle_wr && adr_i == OFS_SHADOW)
        begin
            if (sel_i[0])
                working_shadow <= dat_i[7:0];
            if (sel_i[1])
                flags_shadow <= dat_i[SHADOW_FLAGS_LSB +: 5];
            if (sel_i[2])
                bank_selector_shadow <= dat_i[SHADOW_BANK_LSB +: 4];
        end
    end

    // ==================================================================
    // pc latches: no instruction here writes them
    always_ff @(posedge clk_i)
    begin
        if (rst_i || soft_reset)
        begin
            pc_high_latch <= BYTE_RST;
            pc_upper_latch <= 5'h00;
        end
        else if (idle_wr && adr_i == OFS_LATCH) // returns never land here
        begin
            if (sel_i[0])
                pc_high_latch <= dat_i[7:0];
            if (sel_i[1])
                pc_upper_latch <= dat_i[LATCH_UPPER_LSB +: 5];
        end
    end

    // ==================================================================
    // return stack pointer; overflow and underflow saturate silently
    always_ff @(posedge clk_i)
    begin
        if (rst_i || soft_reset)
            sp <= PTR_RST;
        else if (q2 && (op == OP_PUSH || op == OP_RELATIVE_SUBROUTINE_CALL) && sp != 5'(STACK_DEPTH))
            sp <= sp + 5'h01;
        else if (q3 && op == OP_POP && sp != PTR_RST)
            sp <= sp - 5'h01;
        else if (q4 && (op == OP_IRET || op == OP_LRET) && sp != PTR_RST)
            sp <= sp - 5'h01;
    end

    // stack entries; contents are not cleared by reset, only the pointer
    always_ff @(posedge clk_i)
    begin
        if (q2 && (op == OP_PUSH || op == OP_RELATIVE_SUBROUTINE_CALL) && sp != 5'(STACK_DEPTH))
            stack_mem[sp + 5'h01] <= ret_addr;
    end

    // ==================================================================
    // file operand read in the second phase
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            operand <= BYTE_RST;
        else if (q2 && op == OP_NEGATE)
            operand <= data_mem[file_addr];
    end

    // ==================================================================
    // data memory window for software
    always_ff @(posedge clk_i)
    begin
        if (rst_i || soft_reset)
            mem_addr <= 12'h000;
        else if (idle_wr && adr_i == OFS_MADDR)
            mem_addr <= maddr_wr[11:0];
    end

    // data memory: negate writes back in the fourth phase
    always_ff @(posedge clk_i)
    begin
        if (q4 && op == OP_NEGATE)
            data_mem[file_addr] <= neg_res;
        else if (idle_wr && adr_i == OFS_MDATA && sel_i[0])
            data_mem[mem_addr] <= dat_i[7:0];
    end

endmodule : sre_core

// file: pkg/sre_pkg.sv
// sre_pkg: shared constants, types and decode helpers for the stack/return execution slice
package sre_pkg;

    // ==================================================================
    // register map (byte offsets on the wishbone bus)
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_PC = 8'h08;
    localparam logic [7:0] OFS_WREG = 8'h0c;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_BANK = 8'h14;
    localparam logic [7:0] OFS_INTCTL = 8'h18;
    localparam logic [7:0] OFS_SHADOW = 8'h1c;
    localparam logic [7:0] OFS_LATCH = 8'h20;
    localparam logic [7:0] OFS_STKTOP = 8'h24;
    localparam logic [7:0] OFS_MADDR = 8'h28;
    localparam logic [7:0] OFS_MDATA = 8'h2c;

    // ==================================================================
    // field positions
    localparam int INTCTL_PRIO_BIT = 0;
    localparam int INTCTL_LOW_BIT = 6;
    localparam int INTCTL_HIGH_BIT = 7;
    localparam int SHADOW_FLAGS_LSB = 8;
    localparam int SHADOW_BANK_LSB = 16;
    localparam int LATCH_UPPER_LSB = 8;
    localparam int STAT_PHASE_LSB = 1;
    localparam int STAT_CYCLE_BIT = 3;
    localparam int STAT_PTR_LSB = 4;
    localparam int STAT_UNSUP_BIT = 9;

    // ==================================================================
    // sizes, reset values, timing
    localparam int PC_W = 21;
    localparam int STACK_DEPTH = 31;
    localparam int MEM_WORDS = 4096;
    localparam logic [20:0] PC_RST = 21'h000000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [4:0] PTR_RST = 5'h00;
    localparam logic [1:0] PHASE_LAST = 2'h3; // four clock phases per instruction cycle
    localparam logic [20:0] PC_STEP = 21'h000002;

    // ==================================================================
    // types
    typedef enum logic [3:0] {
        OP_NOP = 4'b0000,
        OP_NEGATE = 4'b0001,
        OP_POP = 4'b0010,
        OP_PUSH = 4'b0011,
        OP_RELATIVE_SUBROUTINE_CALL = 4'b0100,
        OP_SWRESET = 4'b0101,
        OP_IRET = 4'b0110,
        OP_LRET = 4'b0111,
        OP_UNSUP = 4'b1000
    } sre_op_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } sre_state_t;

    typedef struct packed {
        logic neg;
        logic overflow_flag;
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } sre_flags_t;

    // ==================================================================
    // helpers
    function automatic sre_op_t sre_decode(input logic [15:0] ins);
        sre_op_t op;
        op = OP_UNSUP;
        if (ins == 16'h0000 || ins[15:12] == 4'hf)
            op = OP_NOP;
        else if (ins[15:9] == 7'h36)
            op = OP_NEGATE;
        else if (ins == 16'h0006)
            op = OP_POP;
        else if (ins == 16'h0005)
            op = OP_PUSH;
        else if (ins[15:11] == 5'h1b)
            op = OP_RELATIVE_SUBROUTINE_CALL;
        else if (ins == 16'h00ff)
            op = OP_SWRESET;
        else if (ins[15:1] == 15'h0008)
            op = OP_IRET;
        else if (ins[15:8] == 8'h0c)
            op = OP_LRET;
        return op;
    endfunction : sre_decode

    function automatic logic sre_two_cycle(input sre_op_t op);
        return (op == OP_RELATIVE_SUBROUTINE_CALL) || (op == OP_IRET) || (op == OP_LRET);
    endfunction : sre_two_cycle

    function automatic logic [31:0] sre_merge(input logic [31:0] old, input logic [31:0] dat,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                res[i*8 +: 8] = dat[i*8 +: 8];
        end
        return res;
    endfunction : sre_merge

endpackage : sre_pkg

// file: verification/sre_core_asserts.sv
// sre_core_asserts: bus handshake and busy-span assertions for sre_core
`timescale 1ns/1ps
module sre_core_chk
    import sre_pkg::*;
(
    input wire logic clk_i, // core clock
    input wire logic rst_i, // synchronous reset
    input wire logic cyc_i, // bus cycle
    input wire logic stb_i, // bus strobe
    input wire logic we_i, // bus write
    input wire logic [7:0] adr_i, // bus address
    input wire logic [3:0] sel_i, // byte lanes
    input wire logic [31:0] dat_i, // write data
    input wire logic [31:0] dat_o, // read data
    input wire logic ack_o // acknowledge
);
    logic [3:0] cnt;
    logic take;
    logic two;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // a request is taken only while no answer is pending
    assign take = cyc_i && stb_i && !ack_o;
    assign two = dat_i[15:11] == 5'h1b || dat_i[15:1] == 15'h0008 || dat_i[15:8] == 8'h0c;

    // ==================================================================
    // expected busy span: 4 clocks, 8 for the two-cycle ops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt <= 4'h0;
        else if (take && we_i && adr_i == OFS_INSTR && cnt == 4'h0)
            cnt <= two ? 4'h8 : 4'h4;
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end

    // ==================================================================
    // sequences
    sequence bus_take;
        take;
    endsequence
    sequence stat_read;
        take && !we_i && adr_i == OFS_STAT;
    endsequence

    // ==================================================================
    // assertions
    ack_next_a: assert property (bus_take |=> ack_o)
        else $error("no ack one cycle after request");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (ack_o |-> $past(take))
        else $error("ack without request");
    data_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    reset_quiet_a: assert property ($past(rst_i) |-> !ack_o && dat_o == 32'h0)
        else $error("bus answer right after reset");
    unmapped_zero_a: assert property (bus_take ##0 (!we_i && (adr_i > 8'h2c
        || adr_i[1:0] != 2'b00)) |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
    busy_high_a: assert property (stat_read ##0 cnt != 4'h0 |=> dat_o[0])
        else $error("busy low inside instruction");
    busy_low_a: assert property (stat_read ##0 cnt == 4'h0 |=> !dat_o[0])
        else $error("busy high after instruction");
endmodule : sre_core_chk

bind sre_core sre_core_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));

// file: verification/testbench.sv
// testbench: directed scenarios for the stack and return execution slice
`timescale 1ns/1ps
module testbench
    import sre_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic [3:0] msk = 4'hf;
    logic [31:0] rd;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;

    // clock and device
    always #5 clk_i = ~clk_i;
    sre_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));

    // ==================================================================
    // bus and compare helpers
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // request held until ack is sampled, then dropped for one cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= msk;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1)
            @(posedge clk_i);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rchk

    // issue, then poll busy at fixed bus spacing to see the cycle count
    task automatic exec(input logic [15:0] ins, input logic two);
        wr(OFS_INSTR, {16'h0000, ins});
        wb(1'b0, OFS_STAT, 32'h0);
        chk("busy early", 32'h1, {31'h0, rd[0]});
        if (two)
        begin
            wb(1'b0, OFS_STAT, 32'h0);
            chk("busy second cycle", 32'h1, {31'h0, rd[0]});
        end
        wb(1'b0, OFS_STAT, 32'h0);
        chk("busy end", 32'h0, {31'h0, rd[0]});
    endtask : exec

    task automatic t_zero(input string nm);
        logic [7:0] ofs[9] = '{OFS_PC, OFS_WREG, OFS_FLAGS, OFS_BANK, OFS_INTCTL,
            OFS_SHADOW, OFS_LATCH, OFS_STKTOP, OFS_MADDR};
        foreach (ofs[i])
            rchk(ofs[i], 32'h0, "cleared register");
        $display("test %s done", nm);
    endtask : t_zero

    // ==================================================================
    // scenarios
    task automatic t_negate();
        wr(OFS_MADDR, 32'h005);
        wr(OFS_MDATA, 32'h00);
        exec(16'h6c05, 1'b0);
        rchk(OFS_FLAGS, 32'h07, "zero negate flags");
        wr(OFS_BANK, 32'h3);
        wr(OFS_MADDR, 32'h320);
        wr(OFS_MDATA, 32'h3a);
        exec(16'h6d20, 1'b0);
        rchk(OFS_MDATA, 32'hc6, "banked negate");
        rchk(OFS_FLAGS, 32'h10, "negate flags");
        wr(OFS_MADDR, 32'hf90);
        wr(OFS_MDATA, 32'h80);
        exec(16'h6c90, 1'b0);
        rchk(OFS_MDATA, 32'h80, "access bank negate");
        rchk(OFS_FLAGS, 32'h1a, "overflow flags");
        $display("test negate done");
    endtask : t_negate

    task automatic t_stack();
        wr(OFS_PC, 32'h124);
        exec(16'h0005, 1'b0);
        rchk(OFS_STKTOP, 32'h126, "pushed top");
        rchk(OFS_PC, 32'h126, "pc after push");
        exec(16'h0000, 1'b0);
        exec(16'hf123, 1'b0);
        rchk(OFS_PC, 32'h12a, "pc after nops");
        rchk(OFS_STKTOP, 32'h126, "top after nops");
        exec(16'h0005, 1'b0);
        rchk(OFS_STKTOP, 32'h12c, "second top");
        exec(16'h0006, 1'b0);
        rchk(OFS_STKTOP, 32'h126, "top after pop");
        rchk(OFS_FLAGS, 32'h1a, "flags after pop");
        $display("test stack done");
    endtask : t_stack

    task automatic t_call();
        logic [15:0] op[3] = '{16'hdfff, 16'hdbff, 16'hdc00};
        logic [31:0] pc[3] = '{32'h400, 32'hc00, 32'h402};
        wr(OFS_PC, 32'h400);
        for (int i = 0; i < 3; i++)
        begin
            exec(op[i], 1'b1);
            rchk(OFS_PC, pc[i], "call target");
        end
        rchk(OFS_STKTOP, 32'hc02, "return address");
        $display("test call done");
    endtask : t_call

    task automatic t_ret();
        wr(OFS_LATCH, 32'h1f55);
        wr(OFS_WREG, 32'h11);
        wr(OFS_FLAGS, 32'h05);
        wr(OFS_BANK, 32'h2);
        wr(OFS_SHADOW, 32'h0a1a99);
        wr(OFS_INTCTL, 32'h0);
        wr(OFS_PC, 32'h200);
        exec(16'h0005, 1'b0);
        wr(OFS_PC, 32'h300);
        exec(16'h0c42, 1'b1);
        rchk(OFS_WREG, 32'h42, "literal in w");
        rchk(OFS_PC, 32'h202, "pc from top");
        rchk(OFS_FLAGS, 32'h05, "flags kept");
        exec(16'h0005, 1'b0);
        exec(16'h0010, 1'b1);
        rchk(OFS_PC, 32'h204, "pc from top");
        rchk(OFS_INTCTL, 32'h80, "high enable");
        rchk(OFS_WREG, 32'h42, "w kept");
        wr(OFS_INTCTL, 32'h81);
        exec(16'h0005, 1'b0);
        exec(16'h0011, 1'b1);
        rchk(OFS_INTCTL, 32'hc1, "low enable");
        rchk(OFS_WREG, 32'h99, "w restored");
        rchk(OFS_FLAGS, 32'h1a, "flags restored");
        rchk(OFS_BANK, 32'ha, "bank restored");
        rchk(OFS_LATCH, 32'h1f55, "latches kept");
        $display("test returns done");
    endtask : t_ret

    // unmapped place, one lane only, and a write refused while busy
    task automatic t_bus();
        wr(8'h30, 32'h5a);
        rchk(8'h30, 32'h0, "unmapped read");
        msk = 4'h1;
        wr(OFS_SHADOW, 32'hffffff);
        msk = 4'hf;
        rchk(OFS_SHADOW, 32'hff, "lane write");
        wr(OFS_INSTR, 32'hd800);
        wr(OFS_WREG, 32'h77);
        rchk(OFS_WREG, 32'h0, "write while busy");
        rchk(OFS_PC, 32'h2, "zero offset call");
        exec(16'h0001, 1'b0);
        rchk(OFS_STAT, 32'h210, "unsupported flag and pointer");
        rchk(OFS_INSTR, 32'h0001, "last word");
        rchk(OFS_PC, 32'h4, "pc after unsupported");
        exec(16'h0006, 1'b0);
        exec(16'h0006, 1'b0);
        rchk(OFS_STAT, 32'h0, "pop on empty stack");
        $display("test bus done");
    endtask : t_bus

    // ==================================================================
    // main sequence and hang guard
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_zero("reset");
        t_negate();
        t_stack();
        t_call();
        t_ret();
        exec(16'h00ff, 1'b0);
        t_zero("soft reset");
        t_bus();
        summarize();
    end

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            summarize();
        end
    end
endmodule : testbench
